// >>> rtl/sef_defs.svh
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH
// Field widths of the frame marker and backing pointers
`define SEF_SZ_W       7
`define SEF_RRB_W      7
`define SEF_PTR_W      61
// Default physical stacked register count
`define SEF_PHYS_DEF   96
// Register offsets on the local port
`define SEF_REG_CTRL   4'h0
`define SEF_REG_STAT   4'h1
`define SEF_REG_FADDR  4'h2
`define SEF_REG_STORE  4'h3
`define SEF_REG_TOP    4'h4
`define SEF_REG_LOADP  4'h5
`define SEF_REG_DIRTY  4'h6
`define SEF_REG_MARK   4'h7
// Fault cause codes
`define SEF_FC_NONE    4'h0
`define SEF_FC_ILLOP   4'h1
`define SEF_FC_RSVFLD  4'h2
`define SEF_FC_UNIMPL  4'h3
`define SEF_FC_XLATE   4'h4
`define SEF_FC_NATPG   4'h5
`define SEF_FC_NESTED  4'h6
`define SEF_FC_IR_BASE 4'h8
// Instruction op codes
`define SEF_OP_NONE    3'h0
`define SEF_OP_RET     3'h1
`define SEF_OP_IRET    3'h2
`define SEF_OP_RESERVE 3'h3
`define SEF_OP_FLUSH   3'h4
`define SEF_OP_RELOAD  3'h5
`endif

// >>> rtl/sef_pkg.sv
`include "sef_defs.svh"
package sef_pkg;
  typedef struct packed {
    logic [`SEF_SZ_W-1:0]  frame_size;
    logic [`SEF_SZ_W-1:0]  locals_size;
    logic [3:0]            rot_size;
    logic [`SEF_RRB_W-1:0] rotate_base;
  } sef_marker_t;

  typedef enum logic [1:0] {
    SEF_IDLE,
    SEF_FILL,
    SEF_SPILL
  } sef_state_t;

  typedef struct packed {
    logic                  valid;
    logic [3:0]            cause;
    logic                  incomplete;
    logic [`SEF_PTR_W-1:0] addr;
  } sef_fault_t;

  typedef struct packed {
    logic                  req;
    logic                  wr;
    logic [`SEF_PTR_W-1:0] addr;
  } sef_mem_t;
endpackage

// >>> rtl/sef_engine.sv
`timescale 1ns/1ns
`include "sef_defs.svh"
// Summary of operation
// - Oversized return output area zeroes current frame marker instead of restoring.
// - Oversized return still updates rename base and top pointer.
// - Oversized return moves left frame and preserved registers to invalid.
// - Oversized return shrinks dirty count by saved locals size.
// - Oversized return leaves clean count, load pointer, load index alone.
// - Oversized return gives software no fault or other indication.
// - Engine faults are delivered in step with the instruction stream.
// - Background eager spills and fills never raise a fault.
// - A faulting mandatory spill or fill raises a fault.
// - Mandatory stores come only from reserve and flush; fault on issuer.
// - Mandatory load faults from reload report on the reload itself.
// - Frame restore load faults report on target and set incomplete flag.
// - On load fault the store pointer sits above the faulting address.
// - Returns set frame load enable when target frame is not present.
// - Frame load enable stalls execution; only then current frame traffic.
// - Any fault delivery clears frame load enable; bit stays internal.
// - Reserve faults on malformed immediate or resize with rotate base set.
// - Reserve, flush, reload report address, translation, NaT page faults.
// - Return target load faults use incomplete-frame variants of data faults.
// - Nested translation fault when collection disabled for that return kind.
module sef_engine
  import sef_pkg::*;
#(
  parameter int PHYS_STACKED = `SEF_PHYS_DEF
)(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire logic [2:0]            i_op,
  input  wire sef_marker_t           i_saved_marker,
  input  wire logic                  i_imm_bad,
  input  wire logic                  i_coll_en,
  input  wire logic                  i_saved_coll_en,
  input  wire logic                  i_eager_req,
  input  wire logic                  i_eager_wr,
  input  wire logic                  i_mem_ack,
  input  wire logic                  i_mem_fault,
  input  wire logic [3:0]            i_mem_cause,
  input  wire logic [3:0]            i_addr,
  input  wire logic [63:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [63:0]                o_rdata,
  output sef_mem_t                   o_mem,
  output sef_fault_t                 o_fault,
  output logic                       o_stall,
  output sef_marker_t                o_marker
);
  localparam logic [`SEF_SZ_W-1:0] PHYS = PHYS_STACKED[`SEF_SZ_W-1:0];

  initial
  begin
    if (PHYS_STACKED < 1 || PHYS_STACKED > 127)
      $error("PHYS_STACKED out of range");
  end

  typedef struct packed {
    sef_state_t            st;
    sef_marker_t           mark;
    logic [`SEF_SZ_W-1:0]  dirty;
    logic [`SEF_SZ_W-1:0]  clean;
    logic [`SEF_SZ_W-1:0]  ren_base;
    logic [`SEF_SZ_W-1:0]  need;
    logic [`SEF_SZ_W-1:0]  load_idx;
    logic [`SEF_PTR_W-1:0] top_ptr;
    logic [`SEF_PTR_W-1:0] store_ptr;
    logic [`SEF_PTR_W-1:0] load_ptr;
    logic [`SEF_PTR_W-1:0] fault_addr;
    logic                  load_en;
    logic                  ir_mode;
    logic                  mand_issued;
    logic                  nested;
    logic [12:0]           reload_size;
    logic [63:0]           rdata;
    sef_mem_t              mem;
    sef_fault_t            fault;
  } sef_state_reg_t;

  sef_state_reg_t r;
  sef_state_reg_t next_r;

  // Fault code for an instruction's own access, or the restore variant
  function automatic logic [3:0] sef_code(input logic [3:0] c,
                                          input logic ir);
    sef_code = ir ? (`SEF_FC_IR_BASE | c) : c;
  endfunction

  // Pointer step of n registers including collection slots
  function automatic logic [`SEF_PTR_W-1:0] sef_step(
    input logic [`SEF_PTR_W-1:0] p, input logic [`SEF_SZ_W-1:0] n,
    input logic up);
    logic [`SEF_PTR_W-1:0] slots;
    slots = `SEF_PTR_W'(n) + `SEF_PTR_W'((`SEF_PTR_W'(p[5:0]) +
            `SEF_PTR_W'(n)) / `SEF_PTR_W'(63));
    sef_step = up ? p + slots : p - slots;
  endfunction

  logic [`SEF_SZ_W-1:0] out_area;
  logic [`SEF_SZ_W-1:0] free_regs;
  logic                 oversized;
  logic                 is_ret;

  // Compare against counts as held before the return writes anything
  assign out_area  = i_saved_marker.frame_size - i_saved_marker.locals_size;
  assign free_regs = PHYS - r.dirty;
  assign oversized = out_area > free_regs;
  assign is_ret    = (i_op == `SEF_OP_RET) || (i_op == `SEF_OP_IRET);

  always_comb
  begin
    next_r = r;
    next_r.fault.valid = 1'b0;
    next_r.rdata = 64'h0;
    next_r.mem.req = 1'b0;
    // Register port reads, one cycle latency
    if (i_rd)
    begin
      case (i_addr)
        `SEF_REG_CTRL:  next_r.rdata = {51'h0, r.reload_size};
        `SEF_REG_STAT:  next_r.rdata = {62'h0, r.fault.incomplete,
                                        r.st != SEF_IDLE};
        `SEF_REG_FADDR: next_r.rdata = {r.fault_addr, 3'h0};
        `SEF_REG_STORE: next_r.rdata = {r.store_ptr, 3'h0};
        `SEF_REG_TOP:   next_r.rdata = {r.top_ptr, 3'h0};
        `SEF_REG_LOADP: next_r.rdata = {r.load_ptr, 3'h0};
        `SEF_REG_DIRTY: next_r.rdata = {43'h0, r.load_idx, r.clean, r.dirty};
        `SEF_REG_MARK:  next_r.rdata = {39'h0, r.mark};
        default:        next_r.rdata = 64'h0;
      endcase
    end
    // Register port writes
    if (i_wr)
    begin
      case (i_addr)
        `SEF_REG_CTRL:  next_r.reload_size = i_wdata[12:0];
        `SEF_REG_STORE:
        begin
          next_r.store_ptr = i_wdata[63:3];
          next_r.load_ptr  = i_wdata[63:3];
          next_r.top_ptr   = sef_step(i_wdata[63:3], r.dirty, 1'b1);
        end
        default: ;
      endcase
    end
    case (r.st)
      SEF_IDLE:
      begin
        // Background traffic never faults software
        if (i_eager_req && !r.load_en)
        begin
          next_r.mem.req = 1'b1;
          next_r.mem.wr  = i_eager_wr;
          next_r.mem.addr = i_eager_wr ? r.store_ptr : r.load_ptr;
        end
        if (is_ret)
        begin
          // Rename base and top pointer move as a normal return
          next_r.ren_base = r.ren_base - i_saved_marker.locals_size;
          next_r.top_ptr  = sef_step(r.top_ptr,
                                     i_saved_marker.locals_size, 1'b0);
          if (oversized)
          begin
            next_r.mark  = '0;
            // Left frame and preserved regs drop to invalid
            next_r.dirty = r.dirty - i_saved_marker.locals_size;
            // Clean, load pointer, load index kept as is
            // No fault posted on this path
          end
          else
          begin
            next_r.mark = i_saved_marker;
            if (i_saved_marker.locals_size > r.dirty + r.clean)
            begin
              // Target frame not resident: restore it
              next_r.load_en = 1'b1;
              next_r.ir_mode = 1'b1;
              next_r.need = i_saved_marker.locals_size - r.dirty - r.clean;
              next_r.st = SEF_FILL;
              // Latch which collection bit governs this return kind
              next_r.nested = (i_op == `SEF_OP_RET && !i_coll_en) ||
                              (i_op == `SEF_OP_IRET && !i_saved_coll_en);
            end
            else if (i_saved_marker.locals_size > r.dirty)
            begin
              next_r.clean = r.clean - (i_saved_marker.locals_size - r.dirty);
              next_r.dirty = '0;
            end
            else
              next_r.dirty = r.dirty - i_saved_marker.locals_size;
          end
        end
        else if (i_op == `SEF_OP_RESERVE)
        begin
          if (i_imm_bad)
          begin
            next_r.fault = '{1'b1, `SEF_FC_ILLOP, 1'b0, '0};
          end
          else if (r.mark.rotate_base != '0 &&
                   i_saved_marker.rot_size != r.mark.rot_size)
          begin
            next_r.fault = '{1'b1, `SEF_FC_RSVFLD, 1'b0, '0};
          end
          else
          begin
            next_r.mark = i_saved_marker;
            if (i_saved_marker.frame_size > PHYS - r.dirty - r.clean)
            begin
              // Mandatory store from reserve
              next_r.need = i_saved_marker.frame_size - (PHYS - r.dirty);
              next_r.st = SEF_SPILL;
            end
          end
        end
        else if (i_op == `SEF_OP_FLUSH && r.dirty != '0)
        begin
          next_r.need = r.dirty;
          next_r.st = SEF_SPILL;
        end
        else if (i_op == `SEF_OP_RELOAD)
        begin
          // Load back the requested area below the top
          next_r.store_ptr = r.top_ptr - `SEF_PTR_W'(r.reload_size[12:3]);
          next_r.need = r.reload_size[9:3];
          next_r.ir_mode = 1'b0;
          next_r.dirty = '0;
          next_r.clean = '0;
          if (r.reload_size[12:3] != '0)
            next_r.st = SEF_FILL;
        end
      end
      SEF_FILL:
      begin
        // Mandatory fill walks downward from the store pointer
        next_r.mem.req  = !r.mand_issued;
        next_r.mem.wr   = 1'b0;
        next_r.mem.addr = r.store_ptr - `SEF_PTR_W'(1);
        next_r.mand_issued = 1'b1;
        if (i_mem_ack)
        begin
          next_r.mand_issued = 1'b0;
          if (i_mem_fault)
          begin
            // Store pointer left above the faulting word
            next_r.fault_addr = r.store_ptr - `SEF_PTR_W'(1);
            next_r.fault.valid = 1'b1;
            next_r.fault.addr = r.store_ptr - `SEF_PTR_W'(1);
            next_r.fault.incomplete = r.ir_mode;
            next_r.fault.cause = sef_code(i_mem_cause, r.ir_mode);
            if (r.ir_mode && r.nested)
              next_r.fault.cause = sef_code(`SEF_FC_NESTED, 1'b1);
            next_r.load_en = 1'b0;
            next_r.st = SEF_IDLE;
          end
          else
          begin
            next_r.store_ptr = r.store_ptr - `SEF_PTR_W'(1);
            next_r.load_ptr  = r.store_ptr - `SEF_PTR_W'(1);
            next_r.load_idx  = r.load_idx + `SEF_SZ_W'(1);
            next_r.dirty = r.dirty + `SEF_SZ_W'(1);
            next_r.need = r.need - `SEF_SZ_W'(1);
            if (r.need == `SEF_SZ_W'(1))
            begin
              next_r.load_en = 1'b0;
              next_r.st = SEF_IDLE;
            end
          end
        end
      end
      SEF_SPILL:
      begin
        next_r.mem.req  = !r.mand_issued;
        next_r.mem.wr   = 1'b1;
        next_r.mem.addr = r.store_ptr;
        next_r.mand_issued = 1'b1;
        if (i_mem_ack)
        begin
          next_r.mand_issued = 1'b0;
          if (i_mem_fault)
          begin
            // Reported on the issuing instruction
            next_r.fault = '{1'b1, sef_code(i_mem_cause, 1'b0), 1'b0,
                             r.store_ptr};
            next_r.fault_addr = r.store_ptr;
            next_r.st = SEF_IDLE;
          end
          else
          begin
            next_r.store_ptr = r.store_ptr + `SEF_PTR_W'(1);
            next_r.dirty = r.dirty - `SEF_SZ_W'(1);
            next_r.need = r.need - `SEF_SZ_W'(1);
            if (r.need == `SEF_SZ_W'(1))
              next_r.st = SEF_IDLE;
          end
        end
      end
      default: next_r.st = SEF_IDLE;
    endcase
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= '0;
    else if (i_ce)
      r <= next_r;
  end

  // Stall comes from a flop; fault is a one-cycle pulse in step
  always_comb
  begin
    o_rdata  = r.rdata;
    o_mem    = r.mem;
    o_fault  = r.fault;
    o_stall  = r.st != SEF_IDLE;
    o_marker = r.mark;
  end
endmodule // sef_engine

// >>> testbench/sef_engine_assertions.sv
`timescale 1ns/1ns
`include "sef_defs.svh"
// Fault delivery and stall checks seen from the engine ports
module sef_engine_assertions
  import sef_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        i_ce,
  input wire logic [2:0]  i_op,
  input wire logic        i_imm_bad,
  input wire logic        i_mem_ack,
  input wire logic        i_mem_fault,
  input wire sef_fault_t  o_fault,
  input wire logic        o_stall
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Ops are only taken while idle and enabled
  wire take = i_ce && !o_stall;

  fault_pulse_a: assert property (o_fault.valid |=> !o_fault.valid)
    else $error("fault held longer than one cycle");
  fault_unstall_a: assert property (o_fault.valid |-> ##1 !o_stall)
    else $error("stall kept after fault delivery");
  mand_fault_a: assert property (o_stall && i_ce && i_mem_ack
    && i_mem_fault |=> o_fault.valid) else $error("mandatory fault lost");
  eager_quiet_a: assert property (!o_stall && i_mem_ack
    && i_mem_fault |=> !o_fault.valid) else $error("eager access faulted");
  ir_cause_a: assert property (o_fault.valid && o_fault.incomplete
    |-> o_fault.cause[3]) else $error("restore fault without ir cause");
  nested_a: assert property (o_fault.valid && o_fault.cause == 4'hE
    |-> o_fault.incomplete) else $error("nested fault not incomplete");
  illop_a: assert property (take && i_op == `SEF_OP_RESERVE
    && i_imm_bad |=> o_fault.valid && o_fault.cause == `SEF_FC_ILLOP)
    else $error("bad immediate not faulted");
  ret_quiet_a: assert property (take && (i_op == `SEF_OP_RET
    || i_op == `SEF_OP_IRET) |=> !o_fault.valid [*2])
    else $error("return raised a fault at once");
  stall_lim_a: assert property ($rose(o_stall) |-> ##[1:600] !o_stall)
    else $error("stall never ended");
endmodule // sef_engine_assertions

bind sef_engine sef_engine_assertions u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
  .i_op(i_op), .i_imm_bad(i_imm_bad), .i_mem_ack(i_mem_ack),
  .i_mem_fault(i_mem_fault), .o_fault(o_fault), .o_stall(o_stall)
);

// >>> testbench/sef_mem_model.sv
`timescale 1ns/1ns
// Backing store stand-in; one request outstanding at a time
module sef_mem_model
  import sef_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire sef_mem_t   i_mem,
  input  wire logic       i_fail,
  input  wire logic [3:0] i_cause,
  input  wire logic [3:0] i_delay,
  output logic            o_ack,
  output logic            o_fault,
  output logic [3:0]      o_cause
);
  logic [4:0] wait_q;
  // Cause toggles when idle so a stale code is never mistaken for news
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ack   <= 1'b0;
      o_fault <= 1'b0;
      o_cause <= 4'h0;
      wait_q  <= 5'h00;
    end
    else
    begin
      o_ack   <= 1'b0;
      o_fault <= 1'b0;
      o_cause <= ~o_cause;
      if (i_mem.req)
        wait_q <= {1'b0, i_delay} + 5'h01;
      else if (wait_q != 5'h00)
        wait_q <= wait_q - 5'h01;
      if (wait_q == 5'h01)
      begin
        o_ack   <= 1'b1;
        o_fault <= i_fail; // Engine decides if it is mandatory
        o_cause <= i_cause;
      end
    end
  end
endmodule // sef_mem_model

// >>> testbench/tb_sef_engine.sv
`timescale 1ns/1ns
`include "sef_defs.svh"
module tb_sef_engine;
  import sef_pkg::*;
  localparam int PHYS = 16;
  logic        i_ref_clk, i_resetn, i_ce, i_imm_bad, i_coll_en, fail;
  logic        i_saved_coll_en, i_eager_req, i_eager_wr, i_wr, i_rd;
  logic        mem_ack, mem_fault, o_stall;
  logic [2:0]  i_op;
  logic [3:0]  i_addr, mem_cause, fail_cause, delay;
  logic [63:0] i_wdata, o_rdata, d, e;
  sef_marker_t i_saved_marker, o_marker, m;
  sef_mem_t    o_mem;
  sef_fault_t  o_fault, seen;
  int          n_fail, check_count, reqs, wrs;

  sef_engine #(.PHYS_STACKED(PHYS)) DUT (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_op(i_op),
    .i_saved_marker(i_saved_marker), .i_imm_bad(i_imm_bad),
    .i_coll_en(i_coll_en), .i_saved_coll_en(i_saved_coll_en),
    .i_eager_req(i_eager_req), .i_eager_wr(i_eager_wr),
    .i_mem_ack(mem_ack), .i_mem_fault(mem_fault), .i_mem_cause(mem_cause),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mem(o_mem), .o_fault(o_fault),
    .o_stall(o_stall), .o_marker(o_marker));
  sef_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_mem(o_mem), .i_fail(fail), .i_cause(fail_cause), .i_delay(delay),
    .o_ack(mem_ack), .o_fault(mem_fault), .o_cause(mem_cause));

  // 250 MHz core clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] x, y);
    check_count++;
    if (y !== x)
    begin
      $display("Error %s expected %h seen %h", what, x, y);
      n_fail++;
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [63:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [63:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic issue(input logic [2:0] op, input sef_marker_t mk);
    @(posedge i_ref_clk);
    i_op <= op;
    i_saved_marker <= mk;
    @(posedge i_ref_clk);
    i_op <= `SEF_OP_NONE;
  endtask

  // Bounded wait for idle, catching the one-cycle fault and traffic
  task automatic settle(input int lo);
    seen = '0;
    reqs = 0;
    wrs = 0;
    for (int k = 0; k < 400; k++)
    begin
      // Look first, so a fault raised by the op edge is not missed
      #1;
      if (o_fault.valid)
        seen = o_fault;
      reqs += int'(o_mem.req);
      wrs += int'(o_mem.req && o_mem.wr);
      if (k > lo && !o_stall)
        return;
      @(posedge i_ref_clk);
    end
    $display("Error settle expected idle seen busy");
    n_fail++;
    conclude();
  endtask

  // A faulted frame leaves state undefined, so tests start afresh
  task automatic restart();
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    fail <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    wr(`SEF_REG_STORE, 64'h8000);
  endtask

  task automatic t_reset();
    rd(`SEF_REG_MARK, d);
    chk("marker", 64'h0, d);
    rd(4'h8, d);
    chk("unmapped", 64'h0, d);
    $display("test reset done");
  endtask

  task automatic t_oversize();
    restart();
    rd(`SEF_REG_LOADP, e);
    issue(`SEF_OP_RET, '{7'h14, 7'h02, 4'h0, 7'h03});
    settle(4);
    chk("marker", 64'h0, o_marker);
    chk("fault", 64'h0, seen.valid);
    chk("loads", 64'h0, reqs);
    rd(`SEF_REG_LOADP, d);
    chk("load ptr", e, d);
    $display("test oversize done");
  endtask

  task automatic t_return();
    restart();
    delay <= 4'h5;
    m = '{7'h06, 7'h04, 4'h0, 7'h01};
    issue(`SEF_OP_RET, m);
    settle(2);
    chk("marker", m, o_marker);
    chk("fills", 64'h1, reqs > 0);
    chk("fault", 64'h0, seen.valid);
    issue(`SEF_OP_RESERVE, '{7'h06, 7'h04, 4'h2, 7'h00});
    settle(2);
    chk("cause", `SEF_FC_RSVFLD, seen.cause);
    i_imm_bad <= 1'b1;
    issue(`SEF_OP_RESERVE, m);
    settle(2);
    i_imm_bad <= 1'b0;
    chk("cause", `SEF_FC_ILLOP, seen.cause);
    delay <= 4'h0;
    $display("test return done");
  endtask

  task automatic t_rfault(input logic [2:0] op, input logic en,
                          input logic [3:0] code, x);
    restart();
    i_coll_en <= en;
    i_saved_coll_en <= en;
    fail <= 1'b1;
    fail_cause <= code;
    issue(op, '{7'h06, 7'h04, 4'h0, 7'h00});
    settle(2);
    fail <= 1'b0;
    i_coll_en <= 1'b1;
    i_saved_coll_en <= 1'b1;
    chk("cause", x, seen.cause);
    chk("incomplete", 64'h1, seen.incomplete);
    chk("stall", 64'h0, o_stall);
    rd(`SEF_REG_STAT, d);
    chk("status", 64'h1, d[1]);
    rd(`SEF_REG_FADDR, e);
    rd(`SEF_REG_STORE, d);
    chk("store above", 64'h1, d > e);
    $display("test restore fault %h done", x);
  endtask

  task automatic t_reload();
    restart();
    wr(`SEF_REG_CTRL, 64'h20); // Four words, inside the safe bound
    issue(`SEF_OP_RELOAD, '0);
    settle(2);
    chk("fault", 64'h0, seen.valid);
    rd(`SEF_REG_DIRTY, d);
    chk("dirty", 64'h4, d[6:0]);
    fail <= 1'b1;
    fail_cause <= `SEF_FC_UNIMPL;
    issue(`SEF_OP_FLUSH, '0);
    settle(2);
    chk("stores", 64'h1, wrs > 0);
    chk("cause", `SEF_FC_UNIMPL, seen.cause);
    restart();
    wr(`SEF_REG_CTRL, 64'h20);
    fail <= 1'b1;
    fail_cause <= `SEF_FC_NATPG;
    issue(`SEF_OP_RELOAD, '0);
    settle(2);
    chk("cause", `SEF_FC_NATPG, seen.cause);
    chk("incomplete", 64'h0, seen.incomplete);
    $display("test reload done");
  endtask

  // Flushing first keeps a large output area from tripping oversize
  task automatic t_flushret();
    restart();
    wr(`SEF_REG_CTRL, 64'h20);
    issue(`SEF_OP_RELOAD, '0);
    settle(2);
    issue(`SEF_OP_FLUSH, '0);
    settle(2);
    m = '{7'h10, 7'h00, 4'h0, 7'h00};
    issue(`SEF_OP_RET, m);
    settle(2);
    chk("marker", m, o_marker);
    rd(`SEF_REG_DIRTY, d);
    chk("dirty", 64'h0, d[6:0]);
    $display("test flush return done");
  endtask

  task automatic t_eager();
    restart();
    fail <= 1'b1;
    @(posedge i_ref_clk);
    i_eager_req <= 1'b1;
    i_eager_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_eager_req <= 1'b0;
    settle(12);
    chk("eager fault", 64'h0, seen.valid);
    $display("test eager done");
  endtask

  // Main sequence
  initial
  begin
    {i_resetn, i_imm_bad, i_eager_req, i_eager_wr, i_wr, i_rd} = '0;
    {i_op, i_addr, i_wdata, fail, fail_cause, delay} = '0;
    {i_ce, i_coll_en, i_saved_coll_en} = 3'h7;
    i_saved_marker = '0;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_oversize();
    t_return();
    for (int c = 3; c < 6; c++)
      t_rfault(`SEF_OP_RET, 1'b1, 4'(c), 4'h8 | 4'(c));
    t_rfault(`SEF_OP_RET, 1'b0, `SEF_FC_XLATE, 4'hE);
    t_rfault(`SEF_OP_IRET, 1'b0, `SEF_FC_XLATE, 4'hE);
    t_rfault(`SEF_OP_IRET, 1'b1, `SEF_FC_XLATE, 4'hC);
    t_reload();
    t_flushret();
    t_eager();
    conclude();
  end
endmodule // tb_sef_engine
